//--- include/ata_port_pkg.sv
// constants, types and behaviour list for the host port signalling block
// Behaviour
// - host may pause data-in; device stops strobe edges until ready returns.
// - device captures the 16-bit bus on both host data-out strobe edges.
// - host may pause data-out by stopping edges; device waits without error.
// - interrupt negated by hardware reset or by the soft reset bit.
// - interrupt negated when the host writes the command register.
// - interrupt negated when the host reads the status register.
// - interrupt negated when a sector data transfer completes.
// - interrupt floats when device unselected or interrupts disabled.
// - first chip select decodes as a command block register access.
// - second chip select decodes as a control block register access.
// - three binary address lines select the task file register.
// - diagnostic line is input on master, output on slave.
// - slave asserts diagnostic line when self test ends; master watches it.
// - cable line tells an 80-conductor from a 40-conductor cable.
// - activity line multiplexes device activity and slave presence.
// - device presents data so host latches on both data-in strobe edges.
// - device asserts data-out ready when able, negates it to pause.
package ata_port_pkg;
  localparam int          CLK_MHZ        = 25;
  localparam int          UDMA_HALF_NS   = 120;
  localparam int          UDMA_HALF_CYC  = (UDMA_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          PRESENCE_US    = 1000;
  localparam int          PRESENCE_CYC   = PRESENCE_US * CLK_MHZ;
  localparam logic [2:0]  STATUS_ADDR    = 3'h7;
  localparam logic [2:0]  COMMAND_ADDR   = 3'h7;
  // synchroniser vector layout
  localparam int          IX_DIOR        = 0;
  localparam int          IX_DIOW        = 1;
  localparam int          IX_DA          = 2;
  localparam int          IX_CS0         = 5;
  localparam int          IX_CS1         = 6;
  localparam int          IX_DMACK       = 7;
  localparam int          IX_PDIAG       = 8;
  localparam int          IX_CBLID       = 9;
  localparam int          IX_DASP        = 10;
  localparam int          IX_CSEL        = 11;
  localparam int          IX_DD          = 12;
  localparam int          SYNC_W         = 28;
  localparam logic [SYNC_W-1:0] SYNC_RST = 28'hFFFFFFF;

  typedef struct packed {
    logic        valid;
    logic        cmd_blk;
    logic [2:0]  addr;
  } reg_sel_t;

  typedef struct packed {
    logic        cmd_blk;
    logic [2:0]  addr;
    logic [15:0] data;
  } reg_access_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_HOLD} din_state_t;
endpackage

//--- logic/ata_host_port.sv
// device-side signalling of the parallel host port
`timescale 1ns/10ps
module ata_host_port #(
  parameter int PRESENCE_WIN = ata_port_pkg::PRESENCE_CYC
) (
  // clock and reset
  input  wire logic                      CLK_SYS_IN,
  input  wire logic                      RST_B_IN,
  // host strobes, selects, address
  input  wire logic                      DIOR_B_IN,
  input  wire logic                      DIOW_B_IN,
  input  wire logic                      CS0_B_IN,
  input  wire logic                      CS1_B_IN,
  input  wire logic [2:0]                DA_IN,
  input  wire logic                      DMACK_B_IN,
  input  wire logic                      CSEL_IN,
  // data bus
  input  wire logic [15:0]               DD_IN,
  output logic      [15:0]               DD_OUT,
  output logic                           DD_OE_B_OUT,
  // device outputs to host
  output logic                           INTRQ_OUT,
  output logic                           INTRQ_OE_B_OUT,
  output logic                           DSTROBE_OUT,
  output logic                           DDMARDY_B_OUT,
  // open-drain sideband pins
  input  wire logic                      PDIAG_B_IN,
  output logic                           PDIAG_B_OUT,
  output logic                           PDIAG_B_OE_B_OUT,
  input  wire logic                      CBLID_B_IN,
  input  wire logic                      DASP_B_IN,
  output logic                           DASP_B_OUT,
  output logic                           DASP_B_OE_B_OUT,
  // register side towards the drive core
  output ata_port_pkg::reg_access_t      REG_ACC_OUT,
  output logic                           REG_RD_OUT,
  output logic                           REG_WR_OUT,
  input  wire logic [15:0]               REG_RD_DATA_IN,
  // interrupt control from the core
  input  wire logic                      IRQ_SET_IN,
  input  wire logic                      SRST_IN,
  input  wire logic                      NIEN_IN,
  input  wire logic                      SELECTED_IN,
  input  wire logic                      SECTOR_DONE_IN,
  // ultra dma stream
  input  wire logic                      UDMA_IN_EN_IN,
  input  wire logic                      UDMA_OUT_EN_IN,
  input  wire logic [15:0]               DIN_DATA_IN,
  input  wire logic                      DIN_VALID_IN,
  output logic                           DIN_READY_OUT,
  output logic [15:0]                    DOUT_DATA_OUT,
  output logic                           DOUT_VALID_OUT,
  input  wire logic                      DOUT_READY_IN,
  output logic                           BURST_STOP_OUT,
  // status towards the core
  input  wire logic                      DIAG_DONE_IN,
  input  wire logic                      ACTIVE_IN,
  output logic                           IS_MASTER_OUT,
  output logic                           SLAVE_PASSED_OUT,
  output logic                           SLAVE_PRESENT_OUT,
  output logic                           CABLE80_OUT
);
  import ata_port_pkg::*;

  function automatic reg_sel_t decode(input logic [SYNC_W-1:0] v);
    reg_sel_t r;
    r.valid   = ~v[IX_CS0] ^ ~v[IX_CS1];
    r.cmd_blk = ~v[IX_CS0];
    r.addr    = v[IX_DA +: 3];
    return r;
  endfunction

  // three-stage pin synchroniser, change accepted when stages 2 and 3 agree
  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, f_q, f_d, fp_q;
  logic [SYNC_W-1:0] pins;
  assign pins = {DD_IN, CSEL_IN, DASP_B_IN, CBLID_B_IN, PDIAG_B_IN, DMACK_B_IN,
                 CS1_B_IN, CS0_B_IN, DA_IN, DIOW_B_IN, DIOR_B_IN};
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_comb begin
        f_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : f_q[g];
      end
      always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          s1_q[g] <= SYNC_RST[g];
          s2_q[g] <= SYNC_RST[g];
          s3_q[g] <= SYNC_RST[g];
          f_q[g]  <= SYNC_RST[g];
          fp_q[g] <= SYNC_RST[g];
        end else begin
          s1_q[g] <= pins[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          f_q[g]  <= f_d[g];
          fp_q[g] <= f_q[g];
        end
      end
    end
  endgenerate

  logic dma_on, rd_fall, rd_rise, wr_fall, wr_rise, stb_edge, in_burst, out_burst;
  logic stop_f, hdmardy_ok;
  assign dma_on     = ~f_q[IX_DMACK];
  assign rd_fall    = fp_q[IX_DIOR] & ~f_q[IX_DIOR];
  assign rd_rise    = ~fp_q[IX_DIOR] & f_q[IX_DIOR];
  assign wr_fall    = fp_q[IX_DIOW] & ~f_q[IX_DIOW];
  assign wr_rise    = ~fp_q[IX_DIOW] & f_q[IX_DIOW];
  assign stb_edge   = fp_q[IX_DIOR] ^ f_q[IX_DIOR];
  assign in_burst   = dma_on & UDMA_IN_EN_IN;
  assign out_burst  = dma_on & UDMA_OUT_EN_IN;
  assign stop_f     = f_q[IX_DIOW];
  assign hdmardy_ok = ~f_q[IX_DIOR] & ~stop_f;

  // pio register access
  reg_sel_t    sel;
  reg_sel_t    wsel_q, wsel_d;
  reg_access_t acc_q, acc_d;
  logic        rd_q, rd_d, wr_q, wr_d, rdact_q, rdact_d;
  logic        cmd_wr, stat_rd;
  logic [15:0] dd_q, dd_d;
  assign sel = decode(f_q);

  always_comb begin
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    acc_d   = acc_q;
    wsel_d  = wsel_q;
    rdact_d = rdact_q & ~rd_rise;
    if (!dma_on && rd_fall && sel.valid) begin
      rd_d    = 1'b1;
      rdact_d = 1'b1;
      acc_d   = '{cmd_blk: sel.cmd_blk, addr: sel.addr, data: 16'h0000};
    end
    if (!dma_on && wr_fall) begin
      wsel_d = sel;
    end
    if (!dma_on && wr_rise && wsel_q.valid) begin
      wr_d  = 1'b1;
      acc_d = '{cmd_blk: wsel_q.cmd_blk, addr: wsel_q.addr, data: f_q[IX_DD +: 16]};
    end
  end

  assign cmd_wr  = wr_q & acc_q.cmd_blk & (acc_q.addr == COMMAND_ADDR);
  assign stat_rd = rd_q & acc_q.cmd_blk & (acc_q.addr == STATUS_ADDR);

  // interrupt flag, a new request wins over a clear
  logic intrq_q, intrq_d;
  always_comb begin
    intrq_d = intrq_q;
    if (SRST_IN || cmd_wr || stat_rd || SECTOR_DONE_IN) begin
      intrq_d = 1'b0;
    end
    if (IRQ_SET_IN) begin
      intrq_d = 1'b1;
    end
  end
  assign INTRQ_OUT      = intrq_q;
  assign INTRQ_OE_B_OUT = ~(SELECTED_IN & ~NIEN_IN);

  // ultra dma data-in: load word, hold setup time, then toggle strobe
  din_state_t st_q, st_d;
  logic [1:0] cnt_q, cnt_d;
  logic       dstb_q, dstb_d, din_rdy;
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    dstb_d  = dstb_q;
    din_rdy = 1'b0;
    dd_d    = dd_q;
    if (rd_q) begin
      dd_d = REG_RD_DATA_IN;
    end
    case (st_q)
      ST_IDLE: begin
        if (in_burst) begin
          st_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (!in_burst) begin
          st_d = ST_IDLE;
        end else if (DIN_VALID_IN && hdmardy_ok) begin
          dd_d    = DIN_DATA_IN;
          din_rdy = 1'b1;
          cnt_d   = 2'(UDMA_HALF_CYC - 1);
          st_d    = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!in_burst) begin
          st_d = ST_IDLE;
        end else if (cnt_q != 2'h0) begin
          cnt_d = cnt_q - 2'h1;
        end else if (hdmardy_ok) begin
          dstb_d = ~dstb_q;
          st_d   = ST_LOAD;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end
  assign DIN_READY_OUT = din_rdy;
  assign DSTROBE_OUT   = dstb_q;
  assign DD_OUT        = dd_q;
  assign DD_OE_B_OUT   = ~((rdact_q & ~dma_on) | in_burst);

  // ultra dma data-out: capture on both host strobe edges, no timeout
  logic [15:0] dout_q, dout_d;
  logic        dval_q, dval_d;
  always_comb begin
    dout_d = dout_q;
    dval_d = dval_q & ~DOUT_READY_IN;
    if (out_burst && stb_edge) begin
      dout_d = f_q[IX_DD +: 16];
      dval_d = 1'b1;
    end
  end
  assign DOUT_DATA_OUT  = dout_q;
  assign DOUT_VALID_OUT = dval_q;
  assign DDMARDY_B_OUT  = ~(out_burst & ~dval_q);
  assign BURST_STOP_OUT = dma_on & stop_f;

  // master/slave, diagnostics, cable and activity
  logic        master_q, master_d, pres_q, pres_d;
  logic [24:0] win_q, win_d;
  logic        in_win;
  assign in_win = (win_q != 25'h0000000);
  always_comb begin
    master_d = master_q;
    pres_d   = pres_q;
    win_d    = win_q;
    if (in_win) begin
      win_d    = win_q - 25'h0000001;
      master_d = ~f_q[IX_CSEL];
      // own low drive echoes through the filter early in the window
      if (master_q && !f_q[IX_DASP] && (win_q <= 25'(PRESENCE_WIN / 2))) begin
        pres_d = 1'b1;
      end
    end
  end
  assign IS_MASTER_OUT     = master_q;
  assign SLAVE_PRESENT_OUT = pres_q;
  assign SLAVE_PASSED_OUT  = master_q & ~f_q[IX_PDIAG];
  assign CABLE80_OUT       = ~f_q[IX_CBLID];
  assign PDIAG_B_OUT       = 1'b0;
  assign PDIAG_B_OE_B_OUT  = ~(~master_q & DIAG_DONE_IN);
  assign DASP_B_OUT        = 1'b0;
  assign DASP_B_OE_B_OUT   = ~((in_win & ~master_q) | (~in_win & ACTIVE_IN));

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      acc_q    <= '0;
      wsel_q   <= '0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      rdact_q  <= 1'b0;
      intrq_q  <= 1'b0;
      st_q     <= ST_IDLE;
      cnt_q    <= 2'h0;
      dstb_q   <= 1'b0;
      dd_q     <= 16'h0000;
      dout_q   <= 16'h0000;
      dval_q   <= 1'b0;
      master_q <= 1'b0;
      pres_q   <= 1'b0;
      win_q    <= 25'(PRESENCE_WIN);
    end else begin
      acc_q    <= acc_d;
      wsel_q   <= wsel_d;
      rd_q     <= rd_d;
      wr_q     <= wr_d;
      rdact_q  <= rdact_d;
      intrq_q  <= intrq_d;
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      dstb_q   <= dstb_d;
      dd_q     <= dd_d;
      dout_q   <= dout_d;
      dval_q   <= dval_d;
      master_q <= master_d;
      pres_q   <= pres_d;
      win_q    <= win_d;
    end
  end
  assign REG_ACC_OUT = acc_q;
  assign REG_RD_OUT  = rd_q;
  assign REG_WR_OUT  = wr_q;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_cmd_clear;
    cmd_wr && !IRQ_SET_IN;
  endsequence
  sequence s_edge_out;
    $changed(dstb_q);
  endsequence

  chk_intr_cmd_clear: assert property (s_cmd_clear |=> !INTRQ_OUT)
    else $error("interrupt kept after command write");
  chk_intr_stat_clear: assert property (stat_rd && !IRQ_SET_IN |=> !INTRQ_OUT)
    else $error("interrupt kept after status read");
  chk_intr_done_clear: assert property (SECTOR_DONE_IN && !IRQ_SET_IN |=> !INTRQ_OUT)
    else $error("interrupt kept after sector done");
  chk_intr_srst_clear: assert property (SRST_IN && !IRQ_SET_IN |=> !INTRQ_OUT)
    else $error("interrupt kept after soft reset");
  chk_intr_float: assert property (!SELECTED_IN || NIEN_IN |-> INTRQ_OE_B_OUT)
    else $error("interrupt driven while unselected or disabled");
  chk_strobe_pause: assert property (!hdmardy_ok |=> $stable(DSTROBE_OUT))
    else $error("strobe edge while host paused");
  chk_data_setup: assert property (s_edge_out |-> $stable(DD_OUT) && !DD_OE_B_OUT)
    else $error("data moved at strobe edge");
  chk_out_capture: assert property (out_burst && stb_edge |=> DOUT_VALID_OUT
      && DOUT_DATA_OUT == $past(f_q[IX_DD +: 16]))
    else $error("data-out word not captured");
  chk_no_select: assert property (rd_fall && CS0_B_IN && CS1_B_IN && f_q[IX_CS0] && f_q[IX_CS1]
      |=> !REG_RD_OUT)
    else $error("access taken with no chip select");
  chk_diag_dir: assert property (master_q |-> PDIAG_B_OE_B_OUT)
    else $error("master drives diagnostic line");
endmodule // ata_host_port

//--- test/host_port_model.sv
// host side model: host pin timing, pulled-up sideband lines, data bus
`timescale 1ns/10ps
module host_port_model (
  // clock
  input  wire logic        clk_in,
  // device drivers
  input  wire logic [15:0] dev_dd_in,
  input  wire logic        dev_dd_oe_b_in,
  input  wire logic        dev_pdiag_in,
  input  wire logic        dev_pdiag_oe_b_in,
  input  wire logic        dev_dasp_in,
  input  wire logic        dev_dasp_oe_b_in,
  // host pins and resolved lines
  output logic             dior_b_out,
  output logic             diow_b_out,
  output logic             cs0_b_out,
  output logic             cs1_b_out,
  output logic [2:0]       da_out,
  output logic             dmack_b_out,
  output logic [15:0]      dd_out,
  output logic             pdiag_b_out,
  output logic             dasp_b_out,
  output logic             cblid_b_out
);
  logic [15:0] dd_host;
  logic [15:0] dd_last;
  logic        dd_en;
  logic        cable80;
  logic        pdiag_low;
  logic        dasp_low;

  initial begin
    {dior_b_out, diow_b_out, cs0_b_out, cs1_b_out, dmack_b_out} = 5'h1F;
    {da_out, dd_host, dd_last, dd_en, cable80, pdiag_low, dasp_low} = '0;
  end

  always @(posedge clk_in) begin
    dd_last <= dd_out;
  end
  // released bus shows a pattern that changes every cycle
  assign dd_out      = dd_en ? dd_host : (!dev_dd_oe_b_in ? dev_dd_in : ~dd_last);
  // pulled-up lines, low when any party drives low
  assign pdiag_b_out = (dev_pdiag_oe_b_in | dev_pdiag_in) & !pdiag_low;
  assign dasp_b_out  = (dev_dasp_oe_b_in | dev_dasp_in) & !dasp_low;
  assign cblid_b_out = !cable80;

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic side(input logic c80, input logic pd_low, input logic ds_low);
    cable80 = c80;
    pdiag_low = pd_low;
    dasp_low = ds_low;
  endtask

  task automatic reg_start(input logic wr, input logic [1:0] cs_b, input logic [2:0] a,
                           input logic [15:0] d);
    {cs1_b_out, cs0_b_out} = cs_b;
    da_out = a;
    dd_host = d;
    dd_en = wr;
    step(3);
    if (wr) diow_b_out = 1'h0;
    else dior_b_out = 1'h0;
    step(8);
  endtask

  task automatic reg_end();
    dior_b_out = 1'h1;
    diow_b_out = 1'h1;
    step(8);
    {cs1_b_out, cs0_b_out} = 2'h3;
    dd_en = 1'h0;
    step(3);
  endtask

  task automatic dma(input int ph);
    case (ph)
      0: begin
        dmack_b_out = 1'h0;
        step(2);
        diow_b_out = 1'h0;
      end
      1: diow_b_out = 1'h1;
      default: begin
        dmack_b_out = 1'h1;
        dior_b_out = 1'h1;
        dd_en = 1'h0;
      end
    endcase
    step(6);
  endtask

  task automatic hs_edge(input logic [15:0] d);
    dd_host = d;
    dd_en = 1'h1;
    step(2);
    dior_b_out = ~dior_b_out;
    step(2);
  endtask

  task automatic hdmardy(input logic v);
    dior_b_out = v;
    step(1);
  endtask
endmodule // host_port_model

//--- test/test_ata_host_port.sv
// self-checking bench for the host port signalling block
`timescale 1ns/10ps
module test_ata_host_port;
  import ata_port_pkg::*;
  logic        clk, rst_b, csel, irq_set, srst, nien, selected, sector_done;
  logic        udma_in_en, udma_out_en, din_valid, dout_ready, diag_done, active;
  logic        dd_oe_b, intrq, intrq_oe_b, dstrobe, ddmardy_b, pdiag_out, pdiag_oe_b;
  logic        dasp_out, dasp_oe_b, reg_rd, reg_wr, din_ready, dout_valid, burst_stop;
  logic        is_master, slave_passed, slave_present, cable80_out;
  logic        dior_b, diow_b, cs0_b, cs1_b, dmack_b, pdiag_b, dasp_b, cblid_b;
  logic        stb_last = 1'h0;
  logic [2:0]  da;
  logic [15:0] din_data, rd_data, dd_out, dout_data, dd_bus;
  reg_access_t acc, acc_q;
  int          error_cnt = 0, compares = 0, rd_cnt = 0, wr_cnt = 0, stb_cnt = 0;

  ata_host_port #(.PRESENCE_WIN(20)) i_ata_host_port (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .DIOR_B_IN(dior_b), .DIOW_B_IN(diow_b),
    .CS0_B_IN(cs0_b), .CS1_B_IN(cs1_b), .DA_IN(da), .DMACK_B_IN(dmack_b), .CSEL_IN(csel),
    .DD_IN(dd_bus), .DD_OUT(dd_out), .DD_OE_B_OUT(dd_oe_b), .INTRQ_OUT(intrq),
    .INTRQ_OE_B_OUT(intrq_oe_b), .DSTROBE_OUT(dstrobe), .DDMARDY_B_OUT(ddmardy_b),
    .PDIAG_B_IN(pdiag_b), .PDIAG_B_OUT(pdiag_out), .PDIAG_B_OE_B_OUT(pdiag_oe_b),
    .CBLID_B_IN(cblid_b), .DASP_B_IN(dasp_b), .DASP_B_OUT(dasp_out),
    .DASP_B_OE_B_OUT(dasp_oe_b), .REG_ACC_OUT(acc), .REG_RD_OUT(reg_rd), .REG_WR_OUT(reg_wr),
    .REG_RD_DATA_IN(rd_data), .IRQ_SET_IN(irq_set), .SRST_IN(srst), .NIEN_IN(nien),
    .SELECTED_IN(selected), .SECTOR_DONE_IN(sector_done), .UDMA_IN_EN_IN(udma_in_en),
    .UDMA_OUT_EN_IN(udma_out_en), .DIN_DATA_IN(din_data), .DIN_VALID_IN(din_valid),
    .DIN_READY_OUT(din_ready), .DOUT_DATA_OUT(dout_data), .DOUT_VALID_OUT(dout_valid),
    .DOUT_READY_IN(dout_ready), .BURST_STOP_OUT(burst_stop), .DIAG_DONE_IN(diag_done),
    .ACTIVE_IN(active), .IS_MASTER_OUT(is_master), .SLAVE_PASSED_OUT(slave_passed),
    .SLAVE_PRESENT_OUT(slave_present), .CABLE80_OUT(cable80_out));

  host_port_model i_host_port_model (
    .clk_in(clk), .dev_dd_in(dd_out), .dev_dd_oe_b_in(dd_oe_b), .dev_pdiag_in(pdiag_out),
    .dev_pdiag_oe_b_in(pdiag_oe_b), .dev_dasp_in(dasp_out), .dev_dasp_oe_b_in(dasp_oe_b),
    .dior_b_out(dior_b), .diow_b_out(diow_b), .cs0_b_out(cs0_b), .cs1_b_out(cs1_b),
    .da_out(da), .dmack_b_out(dmack_b), .dd_out(dd_bus), .pdiag_b_out(pdiag_b),
    .dasp_b_out(dasp_b), .cblid_b_out(cblid_b));

  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("CHECK FAILED %0t wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic v);
    rst_b = 1'h0;
    csel = v;
    cyc(4);
    rst_b = 1'h1;
  endtask

  // register pulses, captured access, next data-in word on each accepted one
  always @(posedge clk) begin
    if (reg_rd) rd_cnt++;
    if (reg_wr) wr_cnt++;
    if (reg_rd || reg_wr) acc_q = acc;
    if (din_ready === 1'h1 && din_valid) din_data <= din_data + 16'h1;
  end

  // strobe edges judged mid-cycle, away from the edge that moves the bus
  always @(negedge clk) begin
    if (rst_b && dstrobe !== stb_last) begin
      chk(dd_bus, 16'hB000 + 16'(stb_cnt), "data-in word");
      stb_cnt++;
    end
    stb_last = dstrobe;
  end

  task automatic access(input logic wr, input logic [1:0] cs_b, input logic [2:0] a,
                        input logic [15:0] d, input logic take);
    int r;
    int w;
    r = rd_cnt;
    w = wr_cnt;
    rd_data = d;
    i_host_port_model.reg_start(wr, cs_b, a, ~d);
    if (!wr) chk(dd_oe_b, !take, "bus drive in read");
    if (take && !wr) chk(dd_out, d, "read data");
    i_host_port_model.reg_end();
    chk(dd_oe_b, 1'h1, "bus released");
    chk(rd_cnt - r, take && !wr, "read pulse");
    chk(wr_cnt - w, take && wr, "write pulse");
    if (take) chk({acc_q.cmd_blk, acc_q.addr}, {cs_b == 2'h2, a}, "select");
    if (take && wr) chk(acc_q.data, ~d, "write data");
  endtask

  task automatic t_master();
    i_host_port_model.side(1'h0, 1'h0, 1'h1);
    do_reset(1'h0);
    chk(intrq, 1'h0, "irq after reset");
    cyc(40);
    chk(is_master, 1'h1, "master");
    chk(slave_present, 1'h1, "slave seen");
    i_host_port_model.side(1'h1, 1'h1, 1'h0);
    diag_done = slave_present;
    active = slave_present;
    cyc(8);
    chk(cable80_out, 1'h1, "80 conductor");
    chk(slave_passed, 1'h1, "slave passed");
    chk(pdiag_oe_b, 1'h1, "master diag input");
    chk(dasp_oe_b, 1'h0, "activity on");
    i_host_port_model.side(1'h0, 1'h0, 1'h0);
    {active, diag_done} = 2'h0;
    cyc(8);
    chk(cable80_out, 1'h0, "40 conductor");
    chk(slave_passed, 1'h0, "diag idle");
    chk(dasp_oe_b, 1'h1, "activity off");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 16; i++) begin
      access(1'h0, i < 8 ? 2'h2 : 2'h1, 3'(i), {8'h5A, 4'(i), 4'h3}, 1'h1);
      access(1'h1, i < 8 ? 2'h2 : 2'h1, 3'(i), {8'hA5, 4'(i), 4'hC}, 1'h1);
    end
    access(1'h0, 2'h3, 3'h1, 16'h1111, 1'h0);
    access(1'h1, 2'h0, 3'h1, 16'h2222, 1'h0);
  endtask

  task automatic t_irq();
    for (int k = 0; k < 6; k++) begin
      irq_set = 1'h1;
      cyc(1);
      irq_set = 1'h0;
      cyc(1);
      chk(intrq, 1'h1, "irq raised");
      srst = (k == 0);
      sector_done = (k == 3);
      rst_b = (k != 5);
      case (k)
        1: access(1'h1, 2'h2, 3'h7, 16'h00EC, 1'h1);
        2: access(1'h0, 2'h2, 3'h7, 16'h0050, 1'h1);
        4: access(1'h0, 2'h1, 3'h6, 16'h0000, 1'h1);
        default: ;
      endcase
      cyc(1);
      {srst, sector_done, rst_b} = 3'h1;
      cyc(2);
      chk(intrq, k == 4, "irq after event");
    end
    for (int m = 0; m < 4; m++) begin
      {selected, nien} = 2'(m);
      cyc(1);
      chk(intrq_oe_b, m != 2, "irq pin drive");
    end
    {selected, nien} = 2'h2;
    cyc(20);
    chk(slave_present, 1'h0, "no slave after reset");
  endtask

  task automatic t_dma_out();
    int n;
    logic [15:0] w;
    udma_out_en = 1'h1;
    i_host_port_model.dma(0);
    chk(ddmardy_b, 1'h0, "ready for data-out");
    chk(burst_stop, 1'h0, "no stop");
    for (int i = 0; i < 4; i++) begin
      w = 16'hC350 + 16'(i * 257);
      i_host_port_model.hs_edge(w);
      for (n = 0; n < 12 && dout_valid !== 1'h1; n++) cyc(1);
      tmo(n, 12);
      chk(dout_data, w, "data-out word");
      chk(ddmardy_b, 1'h1, "word pending");
      dout_ready = dout_valid;
      cyc(1);
      dout_ready = 1'h0;
      if (i == 1) begin
        cyc(30);
        chk(dout_valid, 1'h0, "host pause");
        chk(ddmardy_b, 1'h0, "ready in pause");
      end
    end
    i_host_port_model.dma(1);
    chk(burst_stop, 1'h1, "stop seen");
    i_host_port_model.dma(2);
    udma_out_en = 1'h0;
  endtask

  task automatic t_dma_in();
    int n;
    int k;
    udma_in_en = 1'h1;
    i_host_port_model.dma(0);
    din_valid = 1'h1;
    cyc(20);
    chk(dd_oe_b, 1'h0, "bus driven");
    chk(stb_cnt, 0, "no strobe before ready");
    i_host_port_model.hdmardy(1'h0);
    for (n = 0; n < 100 && stb_cnt < 2; n++) cyc(1);
    tmo(n, 100);
    i_host_port_model.hdmardy(1'h1);
    cyc(10);
    k = stb_cnt;
    cyc(30);
    chk(stb_cnt, k, "strobe held in pause");
    i_host_port_model.hdmardy(1'h0);
    for (n = 0; n < 100 && stb_cnt < k + 3; n++) cyc(1);
    tmo(n, 100);
    din_valid = 1'h0;
    i_host_port_model.hdmardy(1'h1);
    i_host_port_model.dma(1);
    chk(burst_stop, 1'h1, "stop in data-in");
    i_host_port_model.dma(2);
    udma_in_en = 1'h0;
  endtask

  task automatic t_slave();
    do_reset(1'h1);
    cyc(5);
    chk(dasp_oe_b, 1'h0, "slave presence");
    cyc(30);
    chk(is_master, 1'h0, "slave");
    chk(pdiag_oe_b, 1'h1, "diag before self test");
    diag_done = 1'h1;
    cyc(2);
    chk(pdiag_b, 1'h0, "slave drives diag");
  endtask

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rst_b, csel, irq_set, srst, nien, sector_done, udma_in_en, udma_out_en} = 8'h0;
    {din_valid, dout_ready, diag_done, active} = 4'h0;
    selected = 1'h1;
    din_data = 16'hB000;
    rd_data = 16'h0;
    t_master();
    t_regs();
    t_irq();
    t_dma_out();
    t_dma_in();
    t_slave();
    finish_test();
  end
endmodule // test_ata_host_port
